// *** srr_hold.sv ***
// ============================================================
// Result register that loads its source when upd is set unless frozen.
module srr_hold #(
	parameter int W = 16
) (
	// Clock and reset.
	input  wire logic         clk_sys,
	input  wire logic         rst_b,
	// Source and control.
	input  wire logic [W-1:0] live,
	input  wire logic         upd,
	input  wire logic         frozen,
	// Visible value.
	output logic      [W-1:0] held_q
);

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			held_q <= '0;
		end else if (upd && !frozen) begin
			held_q <= live;
		end
	end

endmodule // srr_hold

// *** srr_regbank.sv ***
// ============================================================
// Shared constants and types.
package srr_pkg;

	// Every register group is six bytes wide.
	localparam int GRP_W = 48;
	localparam int RES_W = 16;
	localparam int CELLS = 16;
	localparam int STC_W = 32;
	localparam int STD_W = 40;

	// Cell group base bit positions in the flat cell vector.
	localparam int CVA_LSB = 0;
	localparam int CVB_LSB = 48;
	localparam int CVC_LSB = 96;
	localparam int CVD_LSB = 144;
	localparam int CVF_LSB = 240;

	// Writable bits of the configuration groups, byte 5 leftmost.
	localparam logic [47:0] CFGA_WMASK = 48'h0F_03_FF_F8_FF_87;
	localparam logic [47:0] CFGB_WMASK = 48'hFF_FF_FF_FF_FF_FF;
	localparam logic [47:0] CFGA_RST   = 48'h00_00_00_00_00_00;
	localparam logic [47:0] CFGB_RST   = 48'h00_00_00_00_00_00;

	// Status bits of configuration group A byte 5.
	localparam int CFGA_FREEZE_BIT = 45;
	localparam int CFGA_MUTE_BIT   = 44;

	// Bytes that read as all ones in the sixth cell group.
	localparam logic [31:0] CVF_FILL = 32'hFFFF_FFFF;

	// Decoded commands as delivered by the link front end.
	typedef enum logic [4:0] {
		SRR_OP_NONE,
		SRR_OP_SNAP,
		SRR_OP_UNSNAP,
		SRR_OP_RET_UNLOCK,
		SRR_OP_RET_WRITE,
		SRR_OP_RET_READ,
		SRR_OP_RD_SERIAL,
		SRR_OP_WR_CFGA,
		SRR_OP_RD_CFGA,
		SRR_OP_WR_CFGB,
		SRR_OP_RD_CFGB,
		SRR_OP_RD_CVA,
		SRR_OP_RD_CVB,
		SRR_OP_RD_CVC,
		SRR_OP_RD_CVD,
		SRR_OP_RD_CVF,
		SRR_OP_RD_STC,
		SRR_OP_RD_STD,
		SRR_OP_CLR_FLAGS
	} srr_op_t;

	typedef enum logic {
		SRR_LIVE,
		SRR_HELD
	} srr_frz_t;

endpackage

module srr_regbank #(
	parameter int          CNT_W     = 6,
	// Arbitrary neutral serial number.
	parameter logic [47:0] SERIAL_ID = 48'h5A5A_0000_0001
) (
	// Clock and reset.
	input  wire logic                                  clk_sys,
	input  wire logic                                  rst_b,
	// Decoded command from the link.
	input  wire logic                                  cmd_vld,
	input  wire srr_pkg::srr_op_t                      cmd_op,
	input  wire logic [srr_pkg::GRP_W-1:0]             cmd_data,
	input  wire logic                                  cmd_pec_ok,
	// Read answer to the link.
	output logic                                       rsp_vld,
	output logic [srr_pkg::GRP_W-1:0]                  rsp_data,
	// Measurement side.
	input  wire logic [srr_pkg::CELLS*srr_pkg::RES_W-1:0] cell_res,
	input  wire logic                                  cell_upd,
	input  wire logic                                  cont_mode,
	input  wire logic                                  redund_en,
	input  wire logic [srr_pkg::STC_W-1:0]             stc_live,
	input  wire logic [srr_pkg::STD_W-1:0]             alert_set,
	input  wire logic                                  discharge_mute_state,
	// Control outputs.
	output logic [srr_pkg::GRP_W-1:0]                  cfga,
	output logic [srr_pkg::GRP_W-1:0]                  cfgb,
	output logic [srr_pkg::GRP_W-1:0]                  retention,
	output logic                                       frozen,
	output logic                                       filter_feed_en,
	output logic                                       redund_cmp_en,
	output logic [CNT_W-1:0]                           cmd_cnt
);
	import srr_pkg::*;

	// ============================================================
	// Freeze state.
	srr_frz_t frz_q;
	logic     frz_now;

	assign frz_now = (frz_q == SRR_HELD);

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			frz_q <= SRR_LIVE;
		end else if (cmd_vld) begin
			case (frz_q)
				SRR_LIVE: begin
					if (cmd_op == SRR_OP_SNAP) begin
						frz_q <= SRR_HELD;
					end
				end
				SRR_HELD: begin
					// A second snapshot falls through and changes nothing.
					if (cmd_op == SRR_OP_UNSNAP) begin
						frz_q <= SRR_LIVE;
					end
				end
				default: begin
					frz_q <= SRR_LIVE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			frozen <= 1'b0;
		end else begin
			frozen <= (frz_q == SRR_HELD);
		end
	end

	// ============================================================
	// Command counter.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cmd_cnt <= '0;
		end else if (cmd_vld) begin
			// Every accepted command counts, snapshot and release included.
			cmd_cnt <= cmd_cnt + 1'b1;
		end
	end

	// ============================================================
	// Converter paths that keep running under the freeze.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			filter_feed_en <= 1'b0;
			redund_cmp_en  <= 1'b0;
		end else begin
			// The freeze only gates the visible registers, not these.
			filter_feed_en <= cont_mode;
			redund_cmp_en  <= redund_en;
		end
	end

	// ============================================================
	// Frozen result registers.
	logic [CELLS*RES_W-1:0] cell_q;
	logic [STC_W-1:0]       stc_q;
	logic [STD_W-1:0]       std_q;
	logic [STD_W-1:0]       alert_acc_q;

	srr_hold #(
		.W (CELLS*RES_W)
	) u_cell_hold (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.live    (cell_res),
		.upd     (cell_upd),
		.frozen  (frz_now),
		.held_q  (cell_q)
	);

	srr_hold #(
		.W (STC_W)
	) u_stc_hold (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.live    (stc_live),
		.upd     (1'b1),
		.frozen  (frz_now),
		.held_q  (stc_q)
	);

	// Flags keep collecting behind the freeze; the visible copy catches up
	// in the first cycle after release. A set in the clear cycle survives.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			alert_acc_q <= '0;
		end else if (cmd_vld && cmd_op == SRR_OP_CLR_FLAGS) begin
			alert_acc_q <= alert_set;
		end else begin
			alert_acc_q <= alert_acc_q | alert_set;
		end
	end

	srr_hold #(
		.W (STD_W)
	) u_std_hold (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.live    (alert_acc_q),
		.upd     (1'b1),
		.frozen  (frz_now),
		.held_q  (std_q)
	);

	// ============================================================
	// Configuration groups.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cfga <= CFGA_RST;
		end else if (cmd_vld && cmd_op == SRR_OP_WR_CFGA) begin
			// Constant-zero and status bits never store a written value.
			cfga <= cmd_data & CFGA_WMASK;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cfgb <= CFGB_RST;
		end else if (cmd_vld && cmd_op == SRR_OP_WR_CFGB) begin
			cfgb <= cmd_data & CFGB_WMASK;
		end
	end

	// ============================================================
	// Retention group.
	logic ret_unlock_q;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ret_unlock_q <= 1'b0;
		end else if (cmd_vld) begin
			// Unlock lasts exactly one following command.
			ret_unlock_q <= (cmd_op == SRR_OP_RET_UNLOCK);
		end
	end

	// No reset here: the contents must outlive sleep and system resets.
	always_ff @(posedge clk_sys) begin
		if (cmd_vld && cmd_op == SRR_OP_RET_WRITE && ret_unlock_q) begin
			// The data check result is deliberately not consulted.
			retention <= cmd_data;
		end
	end

	// ============================================================
	// Read answers.
	logic [GRP_W-1:0] cfga_rd;
	logic [GRP_W-1:0] rd_d;
	logic             rd_hit;

	always_comb begin
		cfga_rd                  = cfga;
		cfga_rd[CFGA_FREEZE_BIT] = frz_now;
		cfga_rd[CFGA_MUTE_BIT]   = discharge_mute_state;
	end

	always_comb begin
		rd_d   = '0;
		rd_hit = 1'b1;
		case (cmd_op)
			SRR_OP_RET_READ:  rd_d = retention;
			SRR_OP_RD_SERIAL: rd_d = SERIAL_ID;
			SRR_OP_RD_CFGA:   rd_d = cfga_rd;
			SRR_OP_RD_CFGB:   rd_d = cfgb;
			SRR_OP_RD_CVA:    rd_d = cell_q[CVA_LSB +: GRP_W];
			SRR_OP_RD_CVB:    rd_d = cell_q[CVB_LSB +: GRP_W];
			SRR_OP_RD_CVC:    rd_d = cell_q[CVC_LSB +: GRP_W];
			SRR_OP_RD_CVD:    rd_d = cell_q[CVD_LSB +: GRP_W];
			SRR_OP_RD_CVF:    rd_d = {CVF_FILL, cell_q[CVF_LSB +: RES_W]};
			SRR_OP_RD_STC:    rd_d = {{(GRP_W-STC_W){1'b0}}, stc_q};
			SRR_OP_RD_STD:    rd_d = {{(GRP_W-STD_W){1'b0}}, std_q};
			default:          rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rsp_vld  <= 1'b0;
			rsp_data <= '0;
		end else begin
			rsp_vld <= cmd_vld && rd_hit;
			if (cmd_vld && rd_hit) begin
				// Reserved bits travel as read so the link checks them too.
				rsp_data <= rd_d;
			end
		end
	end

endmodule // srr_regbank

// *** srr_regbank_checker.sv ***
// ============================================================
// Port checks of the snapshot and retention register bank.
module srr_regbank_checker #(
	parameter int          CNT_W     = 6,
	parameter logic [47:0] SERIAL_ID = 48'h0
) (
	// Clock and reset.
	input wire logic             clk_sys,
	input wire logic             rst_b,
	// Command link.
	input wire logic             cmd_vld,
	input wire srr_pkg::srr_op_t cmd_op,
	input wire logic [47:0]      cmd_data,
	input wire logic             rsp_vld,
	input wire logic [47:0]      rsp_data,
	// Measurement and control.
	input wire logic             cont_mode,
	input wire logic             redund_en,
	input wire logic [47:0]      cfga,
	input wire logic [47:0]      retention,
	input wire logic             frozen,
	input wire logic             filter_feed_en,
	input wire logic             redund_cmp_en,
	input wire logic [CNT_W-1:0] cmd_cnt
);
	import srr_pkg::*;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	// The frozen port trails the internal freeze state by one cycle.
	AST_SNAP: assert property (cmd_vld && cmd_op == SRR_OP_SNAP
		|=> ##1 frozen) else $error("snapshot did not freeze");
	AST_HOLD: assert property ($fell(frozen) |-> $past(cmd_vld, 2) &&
		$past(cmd_op, 2) == SRR_OP_UNSNAP)
		else $error("freeze dropped without release");
	AST_UNSNAP: assert property (cmd_vld && cmd_op == SRR_OP_UNSNAP
		|=> ##1 !frozen) else $error("release left freeze set");
	AST_CNT: assert property (cmd_vld |=> cmd_cnt == $past(cmd_cnt) + 1'b1)
		else $error("command counter did not step");
	AST_FEED: assert property (frozen && cont_mode |=> filter_feed_en)
		else $error("filter feed stopped while frozen");
	AST_CMP: assert property (frozen && redund_en |=> redund_cmp_en)
		else $error("redundant compare stopped while frozen");
	AST_SERIAL: assert property (cmd_vld && cmd_op == SRR_OP_RD_SERIAL
		|=> rsp_vld && rsp_data == SERIAL_ID) else $error("bad serial answer");
	AST_FILL: assert property (cmd_vld && cmd_op == SRR_OP_RD_CVF
		|=> rsp_data[47:16] == CVF_FILL) else $error("bad sixth group fill");
	AST_RET_WR: assert property (cmd_vld && cmd_op == SRR_OP_RET_UNLOCK ##1
		cmd_vld && cmd_op == SRR_OP_RET_WRITE |=> retention == $past(cmd_data))
		else $error("unlocked retention write lost");
	AST_RET_LOCK: assert property (cmd_vld && cmd_op != SRR_OP_RET_UNLOCK ##1
		cmd_vld && cmd_op == SRR_OP_RET_WRITE |=> $stable(retention))
		else $error("locked retention was written");
	AST_ZERO: assert property ((cfga & ~CFGA_WMASK) == '0)
		else $error("fixed zero config bit set");

	COV_RESNAP: cover property (frozen && cmd_vld && cmd_op == SRR_OP_SNAP);
	COV_LIVE_REL: cover property (!frozen && cmd_vld && cmd_op == SRR_OP_UNSNAP);
	COV_RET: cover property (cmd_vld && cmd_op == SRR_OP_RET_WRITE);
endmodule // srr_regbank_checker

bind srr_regbank srr_regbank_checker #(.CNT_W(CNT_W), .SERIAL_ID(SERIAL_ID))
	chk_u (.clk_sys, .rst_b, .cmd_vld, .cmd_op, .cmd_data, .rsp_vld,
	.rsp_data, .cont_mode, .redund_en, .cfga, .retention, .frozen,
	.filter_feed_en, .redund_cmp_en, .cmd_cnt);

// *** srr_host_model.sv ***
// ============================================================
// Host side of the command link.
module srr_host_model (
	// Clock.
	input  wire logic        clk_sys,
	// Commands.
	output logic             cmd_vld,
	output srr_pkg::srr_op_t cmd_op,
	output logic [47:0]      cmd_data,
	output logic             cmd_pec_ok
);
	timeunit 1ns;
	timeprecision 1ps;
	import srr_pkg::*;
	int sent = 0;

	initial begin
		cmd_vld = 1'b0;
		cmd_op = SRR_OP_NONE;
		cmd_data = '0;
		cmd_pec_ok = 1'b1;
	end

	// Request stays up so commands may follow back to back.
	task automatic send(srr_op_t op, logic [47:0] d, logic ok = 1'b1);
		cmd_vld = 1'b1;
		cmd_op = op;
		cmd_data = d;
		cmd_pec_ok = ok;
		@(posedge clk_sys);
		#1;
		sent++;
	endtask

	// A released data bus must not keep showing the last payload.
	task automatic idle();
		cmd_vld = 1'b0;
		cmd_data = ~cmd_data;
		@(posedge clk_sys);
		#1;
	endtask
endmodule // srr_host_model

// *** srr_regbank_test.sv ***
// ============================================================
// Directed test of the snapshot and retention register bank.
module srr_regbank_test;
	timeunit 1ns;
	timeprecision 1ps;
	import srr_pkg::*;
	// Arbitrary serial value.
	localparam logic [47:0] SER = 48'hA5A5_0000_0002;
	logic          clk_sys = 1'b0;
	logic          rst_b = 1'b0;
	logic          cmd_vld, cmd_pec_ok, rsp_vld, frozen;
	srr_op_t       cmd_op;
	logic [47:0]   cmd_data, rsp_data, cfga, cfgb, retention;
	logic [255:0]  cell_res = '0;
	logic [255:0]  old;
	logic          cell_upd = 1'b0;
	logic          cont_mode = 1'b0;
	logic          redund_en = 1'b0;
	logic          discharge_mute_state = 1'b0;
	logic [31:0]   stc_live = 32'h1357_9BDF;
	logic [39:0]   alert_set = '0;
	logic          filter_feed_en, redund_cmp_en;
	logic [5:0]    cmd_cnt;
	int            num_errors = 0;
	int            check_count = 0;

	srr_regbank #(.SERIAL_ID(SER)) dut_u (
		.clk_sys, .rst_b, .cmd_vld, .cmd_op, .cmd_data, .cmd_pec_ok,
		.rsp_vld, .rsp_data, .cell_res, .cell_upd, .cont_mode,
		.redund_en, .stc_live, .alert_set, .discharge_mute_state, .cfga, .cfgb,
		.retention, .frozen, .filter_feed_en, .redund_cmp_en, .cmd_cnt);
	srr_host_model host_u (.clk_sys, .cmd_vld, .cmd_op, .cmd_data,
		.cmd_pec_ok);

	always #25 clk_sys = ~clk_sys;

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(logic [47:0] g, logic [47:0] e);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch at %0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic rd(srr_op_t op, logic [47:0] e);
		host_u.send(op, '0);
		chk(rsp_vld === 1'b1 ? rsp_data : ~e, e);
	endtask

	// New cell results and alert pulses arrive in one cycle.
	task automatic load(logic [15:0] b, logic [39:0] a);
		for (int i = 0; i < 16; i++)
			cell_res[i*16 +: 16] = b + 16'(i);
		alert_set = a;
		cell_upd = 1'b1;
		host_u.idle();
		cell_upd = 1'b0;
		alert_set = '0;
	endtask

	initial begin
		#20us;
		num_errors++;
		give_verdict();
	end

	initial begin
		repeat (8) @(posedge clk_sys);
		#1;
		rst_b = 1'b1;
		discharge_mute_state = 1'b1;
		chk(cfga | cfgb, '0);
		chk({frozen, cmd_cnt}, '0);
		host_u.send(SRR_OP_WR_CFGA, '1);
		host_u.send(SRR_OP_WR_CFGB, 48'h1234_5678_9ABC);
		rd(SRR_OP_RD_CFGA, CFGA_WMASK | 48'h1000_0000_0000);
		rd(SRR_OP_RD_CFGB, 48'h1234_5678_9ABC);
		rd(SRR_OP_RD_SERIAL, SER);
		load(16'h0100, '0);
		for (int k = 0; k < 4; k++)
			rd(srr_op_t'(SRR_OP_RD_CVA + k), cell_res[k*48 +: 48]);
		rd(SRR_OP_RD_CVF, {CVF_FILL, cell_res[CVF_LSB +: 16]});
		old = cell_res;
		host_u.send(SRR_OP_SNAP, '0);
		host_u.send(SRR_OP_SNAP, '0);
		cont_mode = 1'b1;
		redund_en = 1'b1;
		stc_live = 32'h2468_ACE0;
		load(16'h7700, 40'h80_0000_0001);
		chk({frozen, filter_feed_en, redund_cmp_en}, 48'h7);
		rd(SRR_OP_RD_CVA, old[47:0]);
		rd(SRR_OP_RD_CVF, {CVF_FILL, old[CVF_LSB +: 16]});
		rd(SRR_OP_RD_STC, 48'h1357_9BDF);
		rd(SRR_OP_RD_STD, '0);
		rd(SRR_OP_RD_CFGA, CFGA_WMASK | 48'h3000_0000_0000);
		host_u.send(SRR_OP_UNSNAP, '0);
		host_u.idle();
		chk(frozen, '0);
		rd(SRR_OP_RD_STD, 48'h80_0000_0001);
		rd(SRR_OP_RD_STC, 48'h2468_ACE0);
		// A flag raised in the clearing cycle must survive the clear.
		alert_set = 40'h00_0000_0002;
		host_u.send(SRR_OP_CLR_FLAGS, '0);
		alert_set = '0;
		host_u.idle();
		rd(SRR_OP_RD_STD, 48'h2);
		load(16'h2200, '0);
		host_u.send(SRR_OP_UNSNAP, '0);
		rd(SRR_OP_RD_CVA, cell_res[47:0]);
		chk(cmd_cnt, 48'(host_u.sent));
		host_u.send(SRR_OP_RET_UNLOCK, '0);
		host_u.send(SRR_OP_RET_WRITE, 48'hCAFE_0000_BEEF, 1'b0);
		host_u.idle();
		rd(SRR_OP_RET_READ, 48'hCAFE_0000_BEEF);
		host_u.send(SRR_OP_RET_UNLOCK, '0);
		host_u.send(SRR_OP_RD_SERIAL, '0);
		host_u.send(SRR_OP_RET_WRITE, 48'h1);
		host_u.idle();
		rd(SRR_OP_RET_READ, 48'hCAFE_0000_BEEF);
		// A reset in mid-run must leave the retention contents alone.
		host_u.idle();
		rst_b = 1'b0;
		host_u.idle();
		host_u.idle();
		rst_b = 1'b1;
		chk({frozen, cmd_cnt}, '0);
		chk(cfga, '0);
		rd(SRR_OP_RET_READ, 48'hCAFE_0000_BEEF);
		host_u.idle();
		give_verdict();
	end
endmodule // srr_regbank_test
